// [hdl/isg_status_group.sv]
// status group: condition, transition filters, event latch, enable mask
`timescale 1ns/10ps
// How it works
// RULE1 - enable register masks which event bits reach the operation summary bit
// RULE2 - status preset clears every enable bit
// RULE3 - enable and filter registers reset to zero; values are bit weight sums
// RULE4 - clear status clears events but leaves enable untouched
// RULE5 - falling filter bit set: 1-to-0 condition change sets event bit
// RULE6 - rising filter bit set: 0-to-1 condition change sets event bit
// RULE7 - status preset sets all rising filter bits, clears falling bits
// RULE8 - both filter bits set: any transition sets the event bit
// RULE9 - both filter bits clear: no transition ever sets the event bit
// RULE10 - reads return the binary weighted sum of set bits
// RULE11 - separate summary subgroup per phase, indexed one to three
// RULE12 - filtered events latch into read-only event register until cleared
// RULE13 - reading the event register clears it
// RULE14 - instrument reset leaves events alone except captured transitions
// RULE15 - condition register is a read-only live unlatched view
// RULE16 - reading the condition register does not change it
// RULE17 - condition bit clears as soon as its condition goes away
// RULE18 - summary bit is OR of events ANDed with enables, every cycle
module isg_status_group
  import isg_pkg::*;
#(
  parameter int W = ISG_W
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  inst_reset,
  input  wire logic [ISG_GROUPS-1:0][W-1:0] cond_in,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [ISG_GROUPS-1:0] group_summary,
  output logic                       operation_summary_bit
);
  // ==========================================================
  // bus decode
  logic          acc;
  logic          wr;
  logic          rd;
  logic [2:0]    grp;
  logic [11:0]   slot;
  logic          in_grp;
  logic          cmd_hit;
  logic          stat_hit;
  logic          map_ok;
  logic          preset;
  logic          cls;

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign grp      = paddr[7:5];
  assign slot     = {7'h00, paddr[4:0]};
  assign in_grp   = (paddr[11:8] == 4'h0) && (grp < 3'(ISG_GROUPS))
                    && (slot <= ISG_OFF_FALL) && (paddr[1:0] == 2'b00);
  assign cmd_hit  = (paddr == ISG_OFF_CMD);
  assign stat_hit = (paddr == ISG_OFF_STAT);
  assign map_ok   = in_grp | cmd_hit | stat_hit;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~map_ok;
  assign preset   = wr & cmd_hit & pwdata[ISG_CMD_PRESET];
  assign cls      = wr & cmd_hit & pwdata[ISG_CMD_CLS];

  // ==========================================================
  // per group chain, group 0 instrument, 1..3 phases
  logic [ISG_GROUPS-1:0][W-1:0] cond_prev;
  logic [ISG_GROUPS-1:0][W-1:0] event_reg;
  isg_ctl_s [ISG_GROUPS-1:0]    ctl;
  logic [ISG_GROUPS-1:0][W-1:0] captured;

  genvar g;
  generate
    for (g = 0; g < ISG_GROUPS; g++) begin : gen_grp // RULE11
      logic sel;
      logic [W-1:0] rise_ev;
      logic [W-1:0] fall_ev;
      assign sel = in_grp && (grp == 3'(g));
      // edge detection through the filters
      assign rise_ev = cond_in[g] & ~cond_prev[g] & ctl[g].rise; // RULE6
      assign fall_ev = ~cond_in[g] & cond_prev[g] & ctl[g].fall; // RULE5
      assign captured[g] = rise_ev | fall_ev; // RULE8 RULE9

      always_ff @(posedge clk) begin
        if (!rstn) begin
          cond_prev[g] <= '0;
        end else begin
          cond_prev[g] <= cond_in[g];
        end
      end

      // event latch; a captured event beats a read or clear
      always_ff @(posedge clk) begin
        if (!rstn) begin
          event_reg[g] <= '0;
        end else begin
          // inst_reset does not touch events RULE14
          if (cls) begin
            event_reg[g] <= captured[g]; // RULE4
          end else if (rd && sel && slot == ISG_OFF_EVENT) begin
            // only bits already handed out are cleared; later ones stay
            event_reg[g] <= (event_reg[g] & ~prdata[W-1:0])
                            | captured[g]; // RULE13
          end else begin
            event_reg[g] <= event_reg[g] | captured[g]; // RULE12
          end
        end
      end

      // enable and filters
      always_ff @(posedge clk) begin
        if (!rstn || inst_reset) begin
          ctl[g].enable <= W'(ISG_RST_ZERO); // RULE3
          ctl[g].rise   <= W'(ISG_RST_ZERO);
          ctl[g].fall   <= W'(ISG_RST_ZERO);
        end else if (preset) begin
          ctl[g].enable <= W'(ISG_RST_ZERO); // RULE2
          ctl[g].rise   <= W'(ISG_PRESET_RISE); // RULE7
          ctl[g].fall   <= W'(ISG_RST_ZERO);
        end else if (wr && sel) begin
          if (slot == ISG_OFF_ENABLE) ctl[g].enable <= pwdata[W-1:0];
          if (slot == ISG_OFF_RISE)   ctl[g].rise   <= pwdata[W-1:0];
          if (slot == ISG_OFF_FALL)   ctl[g].fall   <= pwdata[W-1:0];
        end
      end

      assign group_summary[g] = |(event_reg[g] & ctl[g].enable); // RULE1
    end
  endgenerate

  assign operation_summary_bit = |group_summary; // RULE18

  // ==========================================================
  // read data, registered at the end of the setup cycle
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = ISG_RD_ZERO;
    if (in_grp) begin
      unique case (slot)
        ISG_OFF_EVENT:  next_prdata = 32'(event_reg[grp[1:0]]); // RULE10
        ISG_OFF_COND:   next_prdata = 32'(cond_in[grp[1:0]]); // RULE15 RULE17
        ISG_OFF_ENABLE: next_prdata = 32'(ctl[grp[1:0]].enable);
        ISG_OFF_RISE:   next_prdata = 32'(ctl[grp[1:0]].rise);
        ISG_OFF_FALL:   next_prdata = 32'(ctl[grp[1:0]].fall);
        default:        next_prdata = ISG_RD_ZERO;
      endcase
    end else if (stat_hit) begin
      next_prdata = 32'({group_summary, operation_summary_bit});
    end
  end

  // read data taken at the end of the setup cycle, so the access cycle
  // shows a flip-flop value; dropped again once the access completes
  logic rd_setup;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= ISG_RD_ZERO;
    end else if (rd_setup) begin
      prdata <= next_prdata; // RULE16
    end else if (acc) begin
      prdata <= ISG_RD_ZERO;
    end
  end

  // ==========================================================
  // checks
  // bus side: zero wait states, refusal, data only in the access
  chk_ready_high: assert property (@(posedge clk) disable iff (!rstn)
    pready)
    else $error("wait state inserted");

  chk_bad_addr: assert property (@(posedge clk) disable iff (!rstn)
    (acc && !map_ok) |-> pslverr)
    else $error("unmapped access not refused");

  chk_idle_data: assert property (@(posedge clk) disable iff (!rstn)
    !acc |-> (prdata == ISG_RD_ZERO))
    else $error("read data outside access");

  chk_bad_wr: assert property (@(posedge clk) disable iff (!rstn)
    (wr && !map_ok && !inst_reset) |=> $stable(ctl))
    else $error("unmapped write changed a control");

  chk_cond_read: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    (rd && in_grp && slot == ISG_OFF_COND)
      |-> (prdata == 32'($past(cond_in[grp[1:0]]))))
    else $error("condition read not live");

  chk_stat_read: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    (rd && stat_hit)
      |-> (prdata == 32'($past({group_summary, operation_summary_bit}))))
    else $error("status read wrong");

  // ==========================================================
  // event chain, watched on single groups or fixed bits of them; chk_summary spans all four groups
  chk_rise_sets: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    (cond_in[1][0] && !cond_prev[1][0] && ctl[1].rise[0])
      |=> event_reg[1][0])
    else $error("rising edge lost");

  chk_fall_sets: assert property (@(posedge clk) disable iff (!rstn) // RULE5
    (!cond_in[2][3] && cond_prev[2][3] && ctl[2].fall[3])
      |=> event_reg[2][3])
    else $error("falling edge lost");

  chk_no_filter: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    (!ctl[3].rise[1] && !ctl[3].fall[1] && !event_reg[3][1] && !cls)
      |=> !event_reg[3][1])
    else $error("event without filter");

  chk_preset_ctl: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    (preset && !inst_reset)
      |=> ((ctl[1].enable == '0) && (ctl[1].rise == '1)
        && (ctl[1].fall == '0)))
    else $error("preset wrong");

  chk_cls_enable: assert property (@(posedge clk) disable iff (!rstn) // RULE4
    (cls && !preset && !inst_reset) |=> $stable(ctl[0].enable))
    else $error("clear status hit enable");

  chk_read_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    (rd && in_grp && grp == 3'd1 && slot == ISG_OFF_EVENT
      && captured[1] == '0)
      |=> ((event_reg[1] & $past(prdata[W-1:0])) == '0))
    else $error("event read not cleared");

  chk_event_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE12
    (event_reg[2][4] && !cls && !(rd && in_grp && grp == 3'd2))
      |=> event_reg[2][4])
    else $error("event bit dropped");

  chk_summary: assert property (@(posedge clk) disable iff (!rstn) // RULE18
    operation_summary_bit == |(event_reg[0] & ctl[0].enable
      | event_reg[1] & ctl[1].enable | event_reg[2] & ctl[2].enable
      | event_reg[3] & ctl[3].enable))
    else $error("summary wrong");

  chk_reset_ev: assert property (@(posedge clk) disable iff (!rstn) // RULE14
    (inst_reset && !cls && !rd)
      |=> event_reg[0] == ($past(event_reg[0]) | $past(captured[0])))
    else $error("reset touched events");

  // ==========================================================
  // per group checks, one set for each group
  generate
    for (g = 0; g < ISG_GROUPS; g++) begin : gen_chk
      chk_both_any: assert property ( // RULE8
        @(posedge clk) disable iff (!rstn)
        ((cond_in[g][2] != cond_prev[g][2])
          && ctl[g].rise[2] && ctl[g].fall[2])
          |=> event_reg[g][2])
        else $error("two way filter missed a change");

      chk_latch_all: assert property ( // RULE12
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> ((event_reg[g] & $past(captured[g]))
          == $past(captured[g])))
        else $error("captured event not latched");

      chk_no_path: assert property ( // RULE9
        @(posedge clk) disable iff (!rstn)
        (captured[g] & ~(ctl[g].rise | ctl[g].fall)) == '0)
        else $error("event passed a closed filter");

      chk_cls_clears: assert property ( // RULE4
        @(posedge clk) disable iff (!rstn)
        cls |=> (event_reg[g] == $past(captured[g])))
        else $error("clear status left events");

      chk_preset_grp: assert property ( // RULE7
        @(posedge clk) disable iff (!rstn)
        (preset && !inst_reset)
          |=> ((ctl[g].rise == '1) && (ctl[g].fall == '0)))
        else $error("preset filters wrong");

      chk_ctl_default: assert property ( // RULE3
        @(posedge clk) disable iff (!rstn)
        inst_reset |=> ((ctl[g].enable == '0) && (ctl[g].rise == '0)
          && (ctl[g].fall == '0)))
        else $error("controls not back to default");

      chk_enable_wr: assert property ( // RULE3
        @(posedge clk) disable iff (!rstn)
        (wr && in_grp && (grp == 3'(g)) && (slot == ISG_OFF_ENABLE)
          && !preset && !inst_reset)
          |=> (ctl[g].enable == $past(pwdata[W-1:0])))
        else $error("enable write lost");

      chk_rise_wr: assert property ( // RULE3
        @(posedge clk) disable iff (!rstn)
        (wr && in_grp && (grp == 3'(g)) && (slot == ISG_OFF_RISE)
          && !preset && !inst_reset)
          |=> (ctl[g].rise == $past(pwdata[W-1:0])))
        else $error("rising filter write lost");

      chk_fall_wr: assert property ( // RULE3
        @(posedge clk) disable iff (!rstn)
        (wr && in_grp && (grp == 3'(g)) && (slot == ISG_OFF_FALL)
          && !preset && !inst_reset)
          |=> (ctl[g].fall == $past(pwdata[W-1:0])))
        else $error("falling filter write lost");

      chk_group_sum: assert property ( // RULE1
        @(posedge clk) disable iff (!rstn)
        group_summary[g] == |(event_reg[g] & ctl[g].enable))
        else $error("group summary wrong");
    end
  endgenerate

  // ==========================================================
  // main scenarios
  cov_preset: cover property (@(posedge clk) disable iff (!rstn) preset);
  cov_summary: cover property (@(posedge clk) disable iff (!rstn)
    $rose(operation_summary_bit));
  cov_read_ev: cover property (@(posedge clk) disable iff (!rstn)
    rd && in_grp && slot == ISG_OFF_EVENT && event_reg[grp[1:0]] != '0);
  cov_two_way: cover property (@(posedge clk) disable iff (!rstn)
    (captured[2] & ctl[2].rise & ctl[2].fall) != '0);
  cov_inst_reset: cover property (@(posedge clk) disable iff (!rstn)
    inst_reset && (event_reg != '0));
endmodule

// [hdl/isg_pkg.sv]
// package: register map and layout for the instrument status group
package isg_pkg;
  // ==========================================================
  // geometry
  localparam int ISG_W       = 16;
  localparam int ISG_PHASES  = 3;
  localparam int ISG_GROUPS  = 4;   // group 0 = instrument, 1..3 = phases
  // ==========================================================
  // register offsets: group base + register slot
  localparam logic [11:0] ISG_GRP_STRIDE = 12'h020;
  localparam logic [11:0] ISG_OFF_EVENT  = 12'h000;
  localparam logic [11:0] ISG_OFF_COND   = 12'h004;
  localparam logic [11:0] ISG_OFF_ENABLE = 12'h008;
  localparam logic [11:0] ISG_OFF_RISE   = 12'h00c;
  localparam logic [11:0] ISG_OFF_FALL   = 12'h010;
  localparam logic [11:0] ISG_OFF_CMD    = 12'h080;
  localparam logic [11:0] ISG_OFF_STAT   = 12'h084;
  // command register bits
  localparam int ISG_CMD_PRESET = 0;
  localparam int ISG_CMD_CLS    = 1;
  // ==========================================================
  // reset and preset values
  localparam logic [15:0] ISG_RST_ZERO = 16'h0000;
  localparam logic [15:0] ISG_PRESET_RISE = 16'hffff;
  localparam logic [31:0] ISG_RD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] rise;
    logic [15:0] fall;
  } isg_ctl_s;
endpackage

// [verification/tb_isg_status_group.sv]
// testbench: apb-driven checks of the instrument status group
`timescale 1ns/10ps
module tb_isg_status_group;
  import isg_pkg::*;
  logic                             clk, rstn, inst_reset;
  logic                             psel, penable, pwrite;
  logic [ISG_GROUPS-1:0][ISG_W-1:0] cond_in;
  logic [11:0]                      paddr;
  logic [31:0]                      pwdata, prdata, lfsr_state;
  logic                             pready, pslverr, operation_summary_bit;
  logic [ISG_GROUPS-1:0]            group_summary;
  logic [32:0]                      exp_q[$];
  int                               fail_count, n_compared, cycles;

  isg_status_group #(.W(ISG_W)) u_isg_status_group (
    .clk(clk), .rstn(rstn), .inst_reset(inst_reset), .cond_in(cond_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .group_summary(group_summary),
    .operation_summary_bit(operation_summary_bit));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] ad(int g, logic [11:0] off);
    return off + ISG_GRP_STRIDE * 12'(g);
  endfunction
  task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic done(string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // read monitor and timeout
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("MISMATCH prdata expected none seen %h", prdata);
      end else check("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    rstn = 0; inst_reset = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; cond_in = '0; lfsr_state = 32'hb50e;
    repeat (4) @(posedge clk);
    rstn <= 1;
    for (int g = 0; g < ISG_GROUPS; g++) begin
      rd(ad(g, ISG_OFF_ENABLE), 33'h0);
      rd(ad(g, ISG_OFF_RISE), 33'h0);
      rd(ad(g, ISG_OFF_FALL), 33'h0);
    end
    done("defaults");
    for (int i = 0; i < 4; i++) begin
      lfsr_state = lfsr(lfsr_state);
      cond_in[3] <= lfsr_state[15:0];
      rd(ad(3, ISG_OFF_COND), {17'h0, lfsr_state[15:0]});
      rd(ad(3, ISG_OFF_COND), {17'h0, lfsr_state[15:0]});
    end
    cond_in[3] <= '0;
    rd(ad(3, ISG_OFF_COND), 33'h0);
    rd(ad(3, ISG_OFF_EVENT), 33'h0);
    done("condition");
    for (int g = 1; g <= ISG_PHASES; g++) begin
      wr(ad(g, ISG_OFF_RISE), 32'h5);
      wr(ad(g, ISG_OFF_FALL), 32'h6);
      cond_in[g] <= 16'h0007;
      rd(ad(g % 3 + 1, ISG_OFF_EVENT), 33'h0);
      rd(ad(g, ISG_OFF_EVENT), 33'h5);
      rd(ad(g, ISG_OFF_EVENT), 33'h0);
      cond_in[g] <= 16'h0000;
      rd(ad(g, ISG_OFF_EVENT), 33'h6);
    end
    done("filters");
    cond_in[1] <= 16'h0001;
    wr(ad(1, ISG_OFF_ENABLE), 32'h2);
    rd(ISG_OFF_STAT, 33'h0);
    wr(ad(1, ISG_OFF_ENABLE), 32'h1);
    rd(ISG_OFF_STAT, 33'h5);
    @(negedge clk);
    check("summary", {28'h0, group_summary, operation_summary_bit}, 33'h5);
    done("mask");
    wr(ISG_OFF_CMD, 32'h1 << ISG_CMD_CLS);
    rd(ad(1, ISG_OFF_EVENT), 33'h0);
    rd(ad(1, ISG_OFF_ENABLE), 33'h1);
    wr(ISG_OFF_CMD, 32'h1 << ISG_CMD_PRESET);
    rd(ad(1, ISG_OFF_ENABLE), 33'h0);
    rd(ad(2, ISG_OFF_RISE), 33'hffff);
    rd(ad(3, ISG_OFF_FALL), 33'h0);
    done("commands");
    cond_in[2] <= 16'h0010;
    rd(ad(2, ISG_OFF_COND), 33'h10);
    inst_reset <= 1;
    @(posedge clk);
    inst_reset <= 0;
    rd(ad(2, ISG_OFF_EVENT), 33'h10);
    rd(12'h0fc, {1'b1, 32'h0});
    done("reset and unmapped");
    @(posedge clk);
    check("queue", 33'(exp_q.size()), 33'h0);
    wrap_up();
  end
endmodule
